// [rtl/bcr_pkg.sv]
// Purpose: shared constants and types for the tester counter and pattern ram block
// Assumes: 8-bit host port with a 4-bit address, one 50 MHz system clock
// Notes: control and status offsets sit with the rest of the register map
package bcr_pkg;
    localparam int CLK_MHZ = 50;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W = 48;
    localparam int ERR_IN_W = 4;
    localparam int RAM_DEPTH = 512;
    localparam int RAM_AW = 9;

    // register offsets
    localparam logic [3:0] OFS_CTRL1 = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_CTRL4 = 4'h3;
    localparam logic [3:0] OFS_END_LO = 4'h4;
    localparam logic [3:0] OFS_END_HI = 4'h5;
    localparam logic [3:0] OFS_TEST = 4'h9;
    localparam logic [3:0] OFS_COUNT0 = 4'hA;
    localparam logic [3:0] OFS_COUNT5 = 4'hF;
    localparam logic [3:0] OFS_RAM_PORT = 4'hF;

    // field positions
    localparam int POS_LATCH = 0;
    localparam int POS_VIEW = 2;
    localparam int POS_OWNER = 3;
    localparam int POS_VERIFY = 4;
    localparam int POS_BIT_OVF = 0;
    localparam int POS_ERR_OVF = 1;
    localparam int POS_IN_SYNC = 2;

    // reset values
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_CTRL4 = 8'h00;
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [8:0] RST_END = 9'h000;
    localparam logic [8:0] RST_PTR = 9'h000;
    localparam logic [47:0] RST_CNT = 48'h000000000000;

    // one sampled view of the host port pins
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [3:0] addr;
        logic [7:0] data;
    } bcr_port_t;

    // one receive-cycle result from the pattern detector
    typedef struct packed {
        logic cycle;
        logic clk_en;
        logic in_sync;
        logic [3:0] err_bits;
    } bcr_rx_t;
endpackage

// [rtl/bcr_pattern_ram.sv]
// Purpose: single-port pattern memory with registered read data
// Assumes: one access per clock, a read in the same cycle as a write returns the old word
// Notes: read data show the word addressed on the previous edge
`timescale 1ns/1ps
module bcr_pattern_ram #(
    parameter int DEPTH = 512,
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic clk, // system clock
    input wire logic we, // write strobe, one cycle
    input wire logic [AW-1:0] addr, // word address
    input wire logic [DW-1:0] wdata, // write data
    output logic [DW-1:0] rdata // registered read data
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// [rtl/bcr_counters.sv]
// Purpose: received-bit and bit-error counters, snapshot registers, host port and
//          indirect pattern ram access for a bit error-rate tester
// Assumes: host port pins are asynchronous and are synchronised here; receive
//          results arrive from same-clock detector logic as one pulse per cycle
// Notes: host strobes take effect on their synchronised edges
// Operation
// - view select bit picks bit count or error count at the count bytes
// - bit counter steps once per receive cycle while clock enable is high
// - bit counter runs regardless of pattern sync
// - bit counter overflow sets its flag and wraps to zero
// - latch bit rising edge snapshots bit count and restarts the counter from that cycle's step
// - error counter counts errored bits and holds while out of sync
// - error counter overflow sets its flag and wraps, keeping the bits added past the top
// - same latch edge snapshots error count and restarts that counter from that cycle's error bits
// - snapshot shown as six bytes, least significant at lowest address
// - 512 byte pattern ram reached only through the port at 0Fh
// - owner bit gives ram to state machine at zero, host at one
// - owner bit rising edge resets ram pointer to zero
// - host write to 0Fh while owning, with verify bit clear, stores byte at pointer
// - pointer advances at rising edge of write strobe
// - verify mode reads byte at pointer from 0Fh and advances pointer
// - overflow flags stay set until the status register is read
// - error gating uses live unlatched sync state
`timescale 1ns/1ps
module bcr_counters #(
    parameter int CNT_WIDTH = 48,
    parameter int RAM_WORDS = 512
) (
    input wire logic clk, // 50 MHz system clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire bcr_pkg::bcr_port_t port_in, // host port pins, asynchronous
    input wire bcr_pkg::bcr_rx_t rx_in, // receive result, same clock
    input wire logic [8:0] sm_ram_addr, // state machine ram address
    output logic [7:0] data_out, // host data bus drive value
    output logic data_oe_n, // host data bus enable, low drives
    output logic [7:0] sm_ram_data, // ram data for the state machine
    output logic [8:0] pattern_end, // last pattern index for the state machine
    output logic ram_owned_by_host // ownership bit as seen by the state machine
);
    import bcr_pkg::*;

    bcr_port_t port_s1;
    bcr_port_t port_s2;
    logic rd_n_d;
    logic wr_n_d;
    logic [7:0] ctrl1;
    logic [7:0] ctrl4;
    logic [7:0] test_reg;
    logic owner_d;
    logic latch_d;
    logic [CNT_WIDTH-1:0] bit_cnt;
    logic [CNT_WIDTH-1:0] err_cnt;
    logic [CNT_WIDTH-1:0] bit_snap;
    logic [CNT_WIDTH-1:0] err_snap;
    logic bit_ovf;
    logic err_ovf;
    logic [8:0] ram_ptr;
    logic [7:0] ram_rdata;

    // decode of the synchronised strobes
    wire selected = !port_s2.cs_n;
    wire rd_fall = selected && rd_n_d && !port_s2.rd_n;
    wire rd_rise = selected && !rd_n_d && port_s2.rd_n;
    wire wr_rise = selected && !wr_n_d && port_s2.wr_n;
    wire [3:0] addr = port_s2.addr;
    wire wr_ctrl1 = wr_rise && (addr == OFS_CTRL1);
    wire wr_ctrl4 = wr_rise && (addr == OFS_CTRL4);
    wire wr_end_lo = wr_rise && (addr == OFS_END_LO);
    wire wr_end_hi = wr_rise && (addr == OFS_END_HI);
    wire wr_test = wr_rise && (addr == OFS_TEST);
    wire rd_status = rd_rise && (addr == OFS_STATUS);

    wire view_err = ctrl4[POS_VIEW];
    wire owner = ctrl4[POS_OWNER];
    wire verify = ctrl4[POS_VERIFY];
    wire owner_rise = owner && !owner_d;
    wire latch_rise = ctrl1[POS_LATCH] && !latch_d;

    // indirect ram port
    wire ram_port = owner && (addr == OFS_RAM_PORT);
    wire ram_wr = wr_rise && ram_port && !verify;
    wire ram_rd_done = rd_rise && ram_port && verify;
    wire [8:0] ram_addr = owner ? ram_ptr : sm_ram_addr;

    // counter arithmetic
    wire rx_step = rx_in.cycle && rx_in.clk_en;
    wire err_step = rx_in.cycle && rx_in.clk_en && rx_in.in_sync;
    wire [CNT_WIDTH:0] bit_sum = {1'b0, bit_cnt} + {{CNT_WIDTH{1'b0}}, rx_step};
    wire [CNT_WIDTH:0] err_sum = {1'b0, err_cnt}
        + {{(CNT_WIDTH + 1 - ERR_IN_W){1'b0}}, rx_in.err_bits};
    wire bit_wrap = rx_step && bit_sum[CNT_WIDTH];
    wire err_wrap = err_step && err_sum[CNT_WIDTH];

    // the counter value after a latch edge keeps this cycle's event
    wire [CNT_WIDTH-1:0] next_bit_cnt = latch_rise
        ? {{(CNT_WIDTH-1){1'b0}}, rx_step}
        : bit_sum[CNT_WIDTH-1:0];
    wire [CNT_WIDTH-1:0] next_err_cnt = latch_rise
        ? (err_step ? {{(CNT_WIDTH-ERR_IN_W){1'b0}}, rx_in.err_bits} : RST_CNT[CNT_WIDTH-1:0])
        : (err_step ? err_sum[CNT_WIDTH-1:0] : err_cnt);

    // six byte view of the selected snapshot
    wire [CNT_WIDTH-1:0] snap_view = view_err ? err_snap : bit_snap;
    wire [3:0] byte_idx = addr - OFS_COUNT0;

    function automatic logic [7:0] snap_byte(input logic [CNT_WIDTH-1:0] v,
                                             input logic [3:0] idx);
        logic [CNT_WIDTH-1:0] shifted;
        shifted = v >> {idx, 3'b000};
        return shifted[7:0];
    endfunction

    wire [7:0] status_byte = {5'h00, rx_in.in_sync, err_ovf, bit_ovf};
    logic [7:0] read_mux;

    always_comb begin
        read_mux = 8'h00;
        if (addr == OFS_CTRL1) begin
            read_mux = ctrl1;
        end else if (addr == OFS_STATUS) begin
            read_mux = status_byte;
        end else if (addr == OFS_CTRL4) begin
            read_mux = ctrl4;
        end else if (addr == OFS_END_LO) begin
            read_mux = pattern_end[7:0];
        end else if (addr == OFS_END_HI) begin
            read_mux = {7'h00, pattern_end[8]};
        end else if (addr == OFS_TEST) begin
            read_mux = test_reg;
        end else if (ram_port && verify) begin
            read_mux = ram_rdata;
        end else if (addr >= OFS_COUNT0) begin
            read_mux = snap_byte(snap_view, byte_idx);
        end
    end

    // pin synchroniser, first stage read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_s1 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
            port_s2 <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 8'h00};
            rd_n_d <= 1'b1;
            wr_n_d <= 1'b1;
        end else begin
            port_s1 <= port_in;
            port_s2 <= port_s1;
            rd_n_d <= port_s2.rd_n;
            wr_n_d <= port_s2.wr_n;
        end
    end

    // control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1 <= RST_CTRL1;
            ctrl4 <= RST_CTRL4;
            test_reg <= RST_TEST;
            pattern_end <= RST_END;
            owner_d <= 1'b0;
            latch_d <= 1'b0;
        end else begin
            if (wr_ctrl1) begin
                ctrl1 <= port_s2.data;
            end
            if (wr_ctrl4) begin
                ctrl4 <= port_s2.data;
            end
            if (wr_test) begin
                test_reg <= port_s2.data;
            end
            if (wr_end_lo) begin
                pattern_end[7:0] <= port_s2.data;
            end
            if (wr_end_hi) begin
                pattern_end[8] <= port_s2.data[0];
            end
            owner_d <= owner;
            latch_d <= ctrl1[POS_LATCH];
        end
    end

    // counters and snapshots
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= RST_CNT[CNT_WIDTH-1:0];
            err_cnt <= RST_CNT[CNT_WIDTH-1:0];
            bit_snap <= RST_CNT[CNT_WIDTH-1:0];
            err_snap <= RST_CNT[CNT_WIDTH-1:0];
        end else begin
            bit_cnt <= next_bit_cnt;
            err_cnt <= next_err_cnt;
            if (latch_rise) begin
                bit_snap <= bit_cnt;
                err_snap <= err_cnt;
            end
        end
    end

    // overflow flags: a new overflow wins over the clearing status read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_ovf <= 1'b0;
            err_ovf <= 1'b0;
        end else begin
            bit_ovf <= bit_wrap || (bit_ovf && !rd_status);
            err_ovf <= err_wrap || (err_ovf && !rd_status);
        end
    end

    // ram address pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ram_ptr <= RST_PTR;
        end else if (owner_rise) begin
            ram_ptr <= RST_PTR;
        end else if (ram_wr || ram_rd_done) begin
            ram_ptr <= ram_ptr + 9'h001;
        end
    end

    // host data bus: capture at read start, release at read end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
            ram_owned_by_host <= 1'b0;
        end else begin
            if (rd_fall) begin
                data_out <= read_mux;
                data_oe_n <= 1'b0;
            end else if (port_s2.rd_n || port_s2.cs_n) begin
                data_oe_n <= 1'b1;
            end
            ram_owned_by_host <= owner;
        end
    end

    assign sm_ram_data = ram_rdata;

    bcr_pattern_ram #(
        .DEPTH(RAM_WORDS),
        .AW(RAM_AW),
        .DW(DATA_W)
    ) u_ram (
        .clk(clk),
        .we(ram_wr),
        .addr(ram_addr),
        .wdata(port_s2.data),
        .rdata(ram_rdata)
    );
endmodule

// [testbench/bcr_props.sv]
// Purpose: port checker for the tester counter and pattern ram block
// Assumes: host pins change just after a rising clock edge
// Notes: bound to every bcr_counters instance
`timescale 1ns/1ps
module bcr_props #(
    parameter int CNT_WIDTH = 48
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire bcr_pkg::bcr_port_t port_in, // host pins
    input wire bcr_pkg::bcr_rx_t rx_in, // receive result
    input wire logic [8:0] sm_ram_addr, // state machine address
    input wire logic [7:0] data_out, // read data
    input wire logic data_oe_n, // bus enable, low drives
    input wire logic [7:0] sm_ram_data, // ram data
    input wire logic [8:0] pattern_end, // last pattern index
    input wire logic ram_owned_by_host // owner copy
);
    import bcr_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property ($fell(port_in.rd_n) && !port_in.cs_n |-> ##[2:5] !data_oe_n)
        else $error("read not answered in time");
    a_read_release: assert property ($rose(port_in.rd_n) |-> ##[1:5] data_oe_n)
        else $error("bus still driven after read");
    a_idle_float: assert property (port_in.rd_n [*6] |-> data_oe_n)
        else $error("bus driven without read");
    a_read_held: assert property (!data_oe_n && $past(!data_oe_n) |-> $stable(data_out))
        else $error("read data moved during read");
    a_unmapped_zero: assert property ((!port_in.cs_n && port_in.addr == 4'h1 && !port_in.rd_n) [*6]
        |-> !data_oe_n && data_out == 8'h00)
        else $error("unmapped read not zero");
    a_owner_hold: assert property (port_in.wr_n [*8] |=> $stable(ram_owned_by_host))
        else $error("owner moved without write");
    a_end_hold: assert property (port_in.wr_n [*8] |=> $stable(pattern_end))
        else $error("pattern end moved without write");
    a_reset_quiet: assert property ($rose(rst_n) |-> data_oe_n && !ram_owned_by_host)
        else $error("outputs wrong after reset");
    c_read: cover property (!data_oe_n);
    c_owner: cover property ($rose(ram_owned_by_host));
    c_end: cover property ($changed(pattern_end));
endmodule
bind bcr_counters bcr_props #(.CNT_WIDTH(CNT_WIDTH)) u_props (.clk(clk), .rst_n(rst_n),
    .port_in(port_in), .rx_in(rx_in), .sm_ram_addr(sm_ram_addr), .data_out(data_out),
    .data_oe_n(data_oe_n), .sm_ram_data(sm_ram_data), .pattern_end(pattern_end),
    .ram_owned_by_host(ram_owned_by_host));

// [testbench/bcr_host.sv]
// Purpose: host processor model on the 8-bit parallel port
// Assumes: device answers within twelve clocks of a read strobe
// Notes: released data bus shows the inverse of the last written byte
`timescale 1ns/1ps
module bcr_host (
    input wire logic clk, // system clock
    input wire logic [7:0] data_out, // device read data
    input wire logic data_oe_n, // device drives when low
    output bcr_pkg::bcr_port_t port_in // host pins
);
    import bcr_pkg::*;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic drv = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wd = 8'h00;
    assign port_in = {cs_n, rd_n, wr_n, addr, drv ? wd : (!data_oe_n ? data_out : ~wd)};
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        wd <= d;
        drv <= 1'b1;
        repeat (3) @(posedge clk);
        wr_n <= 1'b0;
        repeat (5) @(posedge clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        drv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        int n;
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        repeat (3) @(posedge clk);
        rd_n <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (data_oe_n !== 1'b0 && n < 12);
        d = data_out;
        repeat (3) @(posedge clk);
        rd_n <= 1'b1;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
endmodule

// [testbench/bert_counters_pattern_ram_tb.sv]
// Purpose: self-checking bench for the tester counter and pattern ram block
// Assumes: counters shortened to twelve bits so both overflow in one run
// Notes: receive traffic stops while snapshots are taken and read
`timescale 1ns/1ps
module bert_counters_pattern_ram_tb;
    import bcr_pkg::*;
    localparam int CW = 12;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_on = 1'b0;
    bcr_port_t port_in;
    bcr_rx_t rx_in = '0;
    logic [8:0] sm_ram_addr = 9'h000;
    logic [7:0] data_out, sm_ram_data, v;
    logic [7:0] ram_img [5];
    logic data_oe_n, ram_owned_by_host;
    logic [8:0] pattern_end;
    logic [47:0] w;
    logic [1:0] ovf = 2'b00;
    longint bc = 0, ec = 0;
    int n_fail = 0, compares = 0, cyc = 0, seed = 32'h8EBF;
    always #10 clk = ~clk;
    bcr_counters #(.CNT_WIDTH(CW)) DUT (.clk(clk), .rst_n(rst_n), .port_in(port_in),
        .rx_in(rx_in), .sm_ram_addr(sm_ram_addr), .data_out(data_out), .data_oe_n(data_oe_n),
        .sm_ram_data(sm_ram_data), .pattern_end(pattern_end),
        .ram_owned_by_host(ram_owned_by_host));
    bcr_host u_host (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n), .port_in(port_in));
    task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 40000) begin
            n_fail++;
            final_report();
        end
        if (rx_in.cycle && rx_in.clk_en) begin
            bc = bc + 1;
            if (rx_in.in_sync) ec = ec + rx_in.err_bits;
        end
        if ((bc >> CW) != 0) ovf[0] = 1'b1;
        if ((ec >> CW) != 0) ovf[1] = 1'b1;
        bc = bc % (longint'(1) << CW);
        ec = ec % (longint'(1) << CW);
        if (rx_on) begin
            rx_in <= {($random(seed) % 8) != 0, ($random(seed) % 4) != 0, 1'($random(seed)),
                4'($unsigned($random(seed)) % 9)};
            if ($random(seed) % 8 == 0) sm_ram_addr <= 9'($random(seed));
        end else begin
            rx_in <= '0;
        end
    end
    task automatic rd48(input logic [7:0] view, output logic [47:0] r);
        u_host.wr(OFS_CTRL4, view);
        for (int i = 0; i < 6; i++) begin
            u_host.rd(OFS_COUNT0 + 4'(i), v);
            r[8*i +: 8] = v;
        end
    endtask
    task automatic round(input int n);
        rx_on <= 1'b1;
        repeat (n) @(posedge clk);
        rx_on <= 1'b0;
        repeat (3) @(posedge clk);
        u_host.wr(OFS_CTRL1, 8'h00);
        u_host.wr(OFS_CTRL1, 8'h01);
        rd48(8'h00, w);
        chk("bit_count", w, 48'(bc));
        rd48(8'h04, w);
        chk("err_count", w, 48'(ec));
        bc = 0;
        ec = 0;
        u_host.rd(OFS_STATUS, v);
        chk("status", 48'(v & 8'h03), 48'(ovf));
        ovf = 2'b00;
        u_host.rd(OFS_STATUS, v);
        chk("status_clr", 48'(v & 8'h03), 48'h0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        u_host.wr(OFS_TEST, 8'h00);
        u_host.rd(OFS_TEST, v);
        chk("test_reg", 48'(v), 48'h0);
        u_host.rd(4'h1, v);
        chk("unmapped", 48'(v), 48'h0);
        round(300);
        round(9000);
        u_host.wr(OFS_CTRL4, 8'h08);
        for (int i = 0; i < 5; i++) begin
            ram_img[i] = 8'($random(seed));
            u_host.wr(OFS_RAM_PORT, ram_img[i]);
        end
        chk("owner", 48'(ram_owned_by_host), 48'h1);
        u_host.wr(OFS_CTRL4, 8'h00);
        u_host.wr(OFS_END_LO, 8'h04);
        u_host.wr(OFS_END_HI, 8'h00);
        chk("pattern_end", 48'(pattern_end), 48'h4);
        sm_ram_addr <= 9'h002;
        repeat (3) @(posedge clk);
        chk("sm_ram", 48'(sm_ram_data), 48'(ram_img[2]));
        u_host.wr(OFS_CTRL4, 8'h18);
        for (int i = 0; i < 5; i++) begin
            u_host.rd(OFS_RAM_PORT, v);
            chk("ram_verify", 48'(v), 48'(ram_img[i]));
        end
        u_host.wr(OFS_CTRL4, 8'h00);
        final_report();
    end
endmodule
